// *** core/ssl_pkg.sv ***
// ssl_pkg: shared constants and types for the scsi signal layer ends
// assumes: both ends and the testbench refer to it by scope
package ssl_pkg;
  localparam int          NARROW_W      = 8;
  localparam int          WIDE_W        = 32;
  localparam int          LANES         = 4;
  localparam int          MAX_IDS       = 8;
  localparam int          ID_W          = 3;
  localparam logic [3:0]  LANE_EN_RST   = 4'h1;
  localparam int          SETTLE_NS     = 100;
  localparam int          CLK_NS        = 20;
  localparam int          SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  SETTLE_CYC_L  = 4'(SETTLE_CYC);

  // information phase as steered by msg, c/d, i/o
  typedef enum logic [2:0] {
    SSL_PH_DATA_OUT = 3'b000,
    SSL_PH_DATA_IN  = 3'b001,
    SSL_PH_COMMAND  = 3'b010,
    SSL_PH_STATUS   = 3'b011,
    SSL_PH_MSG_OUT  = 3'b110,
    SSL_PH_MSG_IN   = 3'b111
  } ssl_phase_t;

  // odd parity bit for one byte
  function automatic logic odd_par(input logic [7:0] b);
    return ~(^b);
  endfunction
endpackage

// *** core/ssl_bus_if.sv ***
// ssl_bus_if: resolved scsi bus between a target end and an initiator end
// assumes: each end drives an enable per or-tied line, a value per own line, both for data; true means asserted
`timescale 1ns/100ps
interface ssl_bus_if;
  // or-tied lines: enable means assert
  logic        bsy_oe_t, bsy_oe_i, sel_oe_t, sel_oe_i, rst_oe_t, rst_oe_i;
  logic        bsy, sel, rst;
  // target-driven lines
  logic        cd, io, msg, req, reqb;
  // initiator-driven lines
  logic        ack, ackb, atn;
  // data with parity, either end may drive
  logic [31:0] db_t, db_i, db;
  logic [3:0]  dp_t, dp_i, dp;
  logic        db_oe_t, db_oe_i;

  assign bsy = bsy_oe_t | bsy_oe_i;
  assign sel = sel_oe_t | sel_oe_i;
  assign rst = rst_oe_t | rst_oe_i;
  assign db  = (db_oe_t ? db_t : 32'h0000_0000) | (db_oe_i ? db_i : 32'h0000_0000);
  assign dp  = (db_oe_t ? dp_t : 4'h0) | (db_oe_i ? dp_i : 4'h0);

  modport tgt (output bsy_oe_t, sel_oe_t, rst_oe_t, cd, io, msg, req, reqb,
               db_t, dp_t, db_oe_t,
               input bsy, sel, rst, ack, ackb, atn, db, dp);
  modport ini (output bsy_oe_i, sel_oe_i, rst_oe_i, ack, ackb, atn,
               db_i, dp_i, db_oe_i,
               input bsy, sel, rst, cd, io, msg, req, reqb, db, dp);
endinterface

// *** core/ssl_target.sv ***
// ssl_target: target end; selection, reselection, phase lines, req/ack
// assumes: one clk domain, bus lines from the interface are asynchronous
// Summary of operation
// - only the selected pair uses the bus
// - up to eight devices, one id bit each
// - initiator starts, target carries out
// - initiator selects; target requests, may reselect
// - req/ack moves one word per handshake
// - any user asserts or-tied bsy
// - sel or-tied, select or reselect
// - target drives c/d, true for control
// - target drives i/o, true toward initiator
// - target drives msg in message phases
// - target drives req and reqb
// - initiator answers req/reqb with ack/ackb
// - initiator alone drives atn
// - any rst assertion resets every device
// - bit 7 highest priority, falling to 0
// - true line encodes logic one
// - odd parity primary byte, ignored in arbitration
// - odd parity per wide byte lane
// - assert actively, negate by drive or release
// - bsy sel rst only released, never driven false
`timescale 1ns/100ps
module ssl_target #(
  parameter logic [2:0] MY_ID = 3'h0
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // bus
  ssl_bus_if.tgt                    bus,
  // user request
  input  wire logic                 xfer_go,
  input  wire ssl_pkg::ssl_phase_t  xfer_phase,
  input  wire logic [31:0]          xfer_wdata,
  input  wire logic [3:0]           xfer_lanes,
  input  wire logic                 resel_go,
  input  wire logic [2:0]           resel_id,
  input  wire logic                 release_go,
  // user status
  output logic                      selected_r,
  output logic                      xfer_done_r,
  output logic [31:0]               xfer_rdata_r,
  output logic                      par_err_r,
  output logic                      atn_seen_r,
  output logic                      bus_rst_r,
  output logic                      busy_r
);
  typedef enum logic [4:0] {
    SSL_T_IDLE  = 5'b00001,
    SSL_T_CONN  = 5'b00010,
    SSL_T_REQ   = 5'b00100,
    SSL_T_ACKLO = 5'b01000,
    SSL_T_RESEL = 5'b10000
  } ssl_tst_t;

  ssl_tst_t    st_r;
  logic [7:0]  sel_s1_r, sel_s2_r;
  logic [31:0] db_s1_r, db_s2_r;
  logic [3:0]  dp_s1_r, dp_s2_r;
  logic        bsy_s, sel_s, rst_s, ack_s, ackb_s, atn_s;
  logic [3:0]  settle_r;
  logic        wide_r, in_r;
  ssl_pkg::ssl_phase_t ph_r;
  logic [31:0] wdata_r;
  logic [3:0]  lanes_r;
  logic [3:0]  perr;

  // two-stage sync of {bsy,sel,rst,ack,ackb,atn}
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_s1_r <= 8'h00;
      sel_s2_r <= 8'h00;
      db_s1_r  <= 32'h0000_0000;
      db_s2_r  <= 32'h0000_0000;
      dp_s1_r  <= 4'h0;
      dp_s2_r  <= 4'h0;
    end else begin
      sel_s1_r <= {2'b00, bus.bsy, bus.sel, bus.rst, bus.ack, bus.ackb, bus.atn};
      sel_s2_r <= sel_s1_r;
      db_s1_r  <= bus.db;
      db_s2_r  <= db_s1_r;
      dp_s1_r  <= bus.dp;
      dp_s2_r  <= dp_s1_r;
    end
  end
  assign {bsy_s, sel_s, rst_s, ack_s, ackb_s, atn_s} = sel_s2_r[5:0];

  // parity per lane, only for enabled lanes
  genvar g;
  generate
    for (g = 0; g < ssl_pkg::LANES; g++) begin : g_par
      assign perr[g] = lanes_r[g] &
        (dp_s2_r[g] != ssl_pkg::odd_par(db_s2_r[8*g+7:8*g]));
    end
  endgenerate

  // control state machine
  always_ff @(posedge clk) begin
    if (!rstn || rst_s) begin
      st_r        <= SSL_T_IDLE;
      settle_r    <= 4'h0;
      ph_r        <= ssl_pkg::SSL_PH_DATA_OUT;
      wdata_r     <= 32'h0000_0000;
      lanes_r     <= ssl_pkg::LANE_EN_RST;
      in_r        <= 1'b0;
      wide_r      <= 1'b0;
      selected_r  <= 1'b0;
      xfer_done_r <= 1'b0;
      xfer_rdata_r <= 32'h0000_0000;
      par_err_r   <= 1'b0;
      busy_r      <= 1'b0;
    end else begin
      xfer_done_r <= 1'b0;
      case (st_r)
        SSL_T_IDLE: begin
          // selection: sel, no bsy, our id bit set; i/o is not examined
          if (sel_s && !bsy_s && db_s2_r[MY_ID]) begin
            st_r       <= SSL_T_CONN;
            selected_r <= 1'b1;
            busy_r     <= 1'b1;
          end else if (resel_go && !bsy_s && !sel_s) begin
            st_r     <= SSL_T_RESEL;
            settle_r <= ssl_pkg::SETTLE_CYC_L;
            busy_r   <= 1'b1;
          end
        end
        SSL_T_RESEL: begin
          // hold sel and i/o until the initiator answers with bsy
          if (settle_r != 4'h0) begin
            settle_r <= settle_r - 4'h1;
          end else if (bsy_s) begin
            st_r       <= SSL_T_CONN;
            selected_r <= 1'b1;
          end
        end
        SSL_T_CONN: begin
          if (release_go) begin
            st_r       <= SSL_T_IDLE;
            selected_r <= 1'b0;
            busy_r     <= 1'b0;
          end else if (xfer_go && !ack_s && !ackb_s) begin
            st_r    <= SSL_T_REQ;
            ph_r    <= xfer_phase;
            in_r    <= xfer_phase[0];
            wdata_r <= xfer_wdata;
            lanes_r <= xfer_lanes | ssl_pkg::LANE_EN_RST;
            wide_r  <= |xfer_lanes[3:1];
            // i/o must reach the initiator before any data goes out
            settle_r <= ssl_pkg::SETTLE_CYC_L;
          end
        end
        SSL_T_REQ: begin
          // after the settle count, hold req and data until ack, and ackb when wide, is seen
          if (settle_r != 4'h0) begin
            settle_r <= settle_r - 4'h1;
          end else if (ack_s && (ackb_s || !wide_r)) begin
            st_r <= SSL_T_ACKLO;
            if (!in_r) begin
              xfer_rdata_r <= db_s2_r;
              par_err_r    <= |perr;
            end
          end
        end
        SSL_T_ACKLO: begin
          if (!ack_s && !ackb_s) begin
            st_r        <= SSL_T_CONN;
            xfer_done_r <= 1'b1;
          end
        end
        default: st_r <= SSL_T_IDLE;
      endcase
    end
  end

  // attention and reset seen by the user
  always_ff @(posedge clk) begin
    if (!rstn) begin
      atn_seen_r <= 1'b0;
      bus_rst_r  <= 1'b0;
    end else begin
      atn_seen_r <= atn_s && selected_r;
      bus_rst_r  <= rst_s;
    end
  end

  // bus drive: or-tied lines only ever asserted
  logic conn, drive, hs;
  assign conn  = (st_r != SSL_T_IDLE);
  assign hs    = (st_r == SSL_T_REQ) && (settle_r == 4'h0);
  assign drive = hs && in_r;
  assign bus.bsy_oe_t = conn && (st_r != SSL_T_RESEL || settle_r == 4'h0) && selected_r;
  assign bus.sel_oe_t = (st_r == SSL_T_RESEL);
  assign bus.rst_oe_t = 1'b0;
  assign bus.cd   = selected_r && ph_r[1];
  assign bus.io   = (st_r == SSL_T_RESEL) || (selected_r && in_r);
  assign bus.msg  = selected_r && ph_r[2];
  assign bus.req  = hs;
  assign bus.reqb = hs && wide_r;
  assign bus.db_oe_t = drive || (st_r == SSL_T_RESEL);
  assign bus.db_t = (st_r == SSL_T_RESEL) ?
                    ((32'h0000_0001 << MY_ID) | (32'h0000_0001 << resel_id)) : wdata_r;
  generate
    for (g = 0; g < ssl_pkg::LANES; g++) begin : g_dp
      assign bus.dp_t[g] = ssl_pkg::odd_par(bus.db_t[8*g+7:8*g]);
    end
  endgenerate
endmodule // ssl_target

// *** core/ssl_initiator.sv ***
// ssl_initiator: initiator end; selection, ack answers, atn, bus reset
// assumes: one clk domain, target lines from the interface are asynchronous
`timescale 1ns/100ps
module ssl_initiator #(
  parameter logic [2:0] MY_ID = 3'h7
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // bus
  ssl_bus_if.ini           bus,
  // user request
  input  wire logic        sel_go,
  input  wire logic [2:0]  sel_id,
  input  wire logic        atn_set,
  input  wire logic        rst_go,
  input  wire logic [31:0] out_data,
  // user status
  output logic             connected_r,
  output logic             word_r,
  output logic [31:0]      in_data_r,
  output logic             par_err_r,
  output logic             bus_rst_r
);
  typedef enum logic [2:0] {
    SSL_I_IDLE = 3'b001,
    SSL_I_SEL  = 3'b010,
    SSL_I_CONN = 3'b100
  } ssl_ist_t;

  ssl_ist_t    st_r;
  logic [7:0]  c1_r, c2_r;
  logic [31:0] db1_r, db2_r;
  logic [3:0]  dp1_r, dp2_r;
  logic        bsy_s, sel_s, rst_s, req_s, reqb_s, io_s;
  logic        ack_r, ackb_r, atn_r, rst_r;
  logic [3:0]  perr;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      c1_r  <= 8'h00;
      c2_r  <= 8'h00;
      db1_r <= 32'h0000_0000;
      db2_r <= 32'h0000_0000;
      dp1_r <= 4'h0;
      dp2_r <= 4'h0;
    end else begin
      c1_r  <= {2'b00, bus.bsy, bus.sel, bus.rst, bus.req, bus.reqb, bus.io};
      c2_r  <= c1_r;
      db1_r <= bus.db;
      db2_r <= db1_r;
      dp1_r <= bus.dp;
      dp2_r <= dp1_r;
    end
  end
  assign {bsy_s, sel_s, rst_s, req_s, reqb_s, io_s} = c2_r[5:0];

  genvar g;
  generate
    for (g = 0; g < ssl_pkg::LANES; g++) begin : g_par
      assign perr[g] = dp2_r[g] != ssl_pkg::odd_par(db2_r[8*g+7:8*g]);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn || rst_s) begin
      st_r        <= SSL_I_IDLE;
      connected_r <= 1'b0;
      ack_r       <= 1'b0;
      ackb_r      <= 1'b0;
      word_r      <= 1'b0;
      in_data_r   <= 32'h0000_0000;
      par_err_r   <= 1'b0;
    end else begin
      word_r <= 1'b0;
      case (st_r)
        SSL_I_IDLE: begin
          if (sel_go && !bsy_s && !sel_s) begin
            st_r <= SSL_I_SEL;
          end else if (sel_s && io_s && db2_r[MY_ID]) begin
            st_r        <= SSL_I_CONN;
            connected_r <= 1'b1;
          end
        end
        SSL_I_SEL: begin
          if (bsy_s) begin
            st_r        <= SSL_I_CONN;
            connected_r <= 1'b1;
          end
        end
        SSL_I_CONN: begin
          if (!bsy_s && !sel_s) begin
            st_r        <= SSL_I_IDLE;
            connected_r <= 1'b0;
          end
          ack_r  <= req_s;
          ackb_r <= reqb_s;
          if (req_s && !ack_r) begin
            word_r <= 1'b1;
            if (io_s) begin
              in_data_r <= db2_r;
              par_err_r <= perr[0] | (reqb_s & |perr[3:1]);
            end
          end
        end
        default: st_r <= SSL_I_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      atn_r     <= 1'b0;
      rst_r     <= 1'b0;
      bus_rst_r <= 1'b0;
    end else begin
      atn_r     <= atn_set;
      rst_r     <= rst_go;
      bus_rst_r <= rst_s;
    end
  end

  logic drv;
  assign drv = (st_r == SSL_I_SEL) || (st_r == SSL_I_CONN && !io_s);
  assign bus.bsy_oe_i = (st_r == SSL_I_CONN) && io_s && sel_s;
  assign bus.sel_oe_i = (st_r == SSL_I_SEL);
  assign bus.rst_oe_i = rst_r;
  assign bus.ack  = ack_r;
  assign bus.ackb = ackb_r;
  assign bus.atn  = atn_r;
  assign bus.db_oe_i = drv;
  assign bus.db_i = (st_r == SSL_I_SEL) ?
                    ((32'h0000_0001 << MY_ID) | (32'h0000_0001 << sel_id)) : out_data;
  generate
    for (g = 0; g < ssl_pkg::LANES; g++) begin : g_dp
      assign bus.dp_i[g] = ssl_pkg::odd_par(bus.db_i[8*g+7:8*g]);
    end
  endgenerate
endmodule // ssl_initiator

// *** verification/ssl_bus_chk.sv ***
// ssl_bus_chk: assertions on the resolved bus between target and initiator
// assumes: signals taken from ssl_bus_if, one clk domain, rstn sync active low
`timescale 1ns/100ps
module ssl_bus_chk (
  // clock and reset
  input logic        clk,
  input logic        rstn,
  // control lines
  input logic        rst,
  input logic        req,
  input logic        reqb,
  input logic        ack,
  input logic        ackb,
  input logic        cd,
  input logic        io,
  input logic        msg,
  // data lines
  input logic [31:0] db,
  input logic [3:0]  dp,
  input logic        db_oe_t,
  input logic        db_oe_i
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || rst);

  one_driver_a: assert property (!(db_oe_t && db_oe_i))
    else $error("both ends drive data");
  par_narrow_a: assert property (ack && req |-> dp[0] == ~^db[7:0])
    else $error("lane 0 parity wrong");
  par_wide_a: assert property (ackb && reqb |->
    dp[3:1] == {~^db[31:24], ~^db[23:16], ~^db[15:8]})
    else $error("wide parity wrong");
  req_stands_a: assert property (req && !ack |=> req)
    else $error("req dropped before ack");
  ack_answer_a: assert property ($rose(req) |-> ##[2:4] ack)
    else $error("ack late");
  ack_cause_a: assert property ($rose(ack) |-> req)
    else $error("ack without req");
  ackb_cause_a: assert property ($rose(ackb) |-> reqb)
    else $error("ackb without reqb");
  phase_steady_a: assert property (req && $past(req) |-> $stable({msg, cd, io}))
    else $error("phase moved under req");
  dir_in_a: assert property (req && db_oe_t |-> io)
    else $error("target drives data outward");
  rst_clears_a: assert property (disable iff (!rstn) rst |-> ##[0:4] !req)
    else $error("req survives bus reset");

  cover property ($rose(req) && io);
  cover property ($rose(req) && !io);
  cover property ($rose(reqb));
  cover property ($rose(rst));
endmodule // ssl_bus_chk

// *** verification/scsi_bus_signal_layer_tb.sv ***
// scsi_bus_signal_layer_tb: target and initiator joined by one bus interface
// assumes: 50 MHz clk, rstn held low two cycles at start
`timescale 1ns/100ps
module scsi_bus_signal_layer_tb;
  logic clk, rstn, xfer_go, resel_go, release_go, sel_go, atn_set, rst_go;
  logic t_sel, t_done, t_perr, t_atn, t_rst, t_busy, i_conn, i_word, i_perr, i_rst;
  logic [31:0] xfer_wdata, out_data, t_rdata, i_rdata;
  logic [3:0]  xfer_lanes;
  logic [2:0]  resel_id, sel_id;
  ssl_pkg::ssl_phase_t xfer_phase;
  int errors, n_tests, k;

  ssl_bus_if ssl_bus_if_i ();
  ssl_target #(.MY_ID(3'h0)) ssl_target_i (.clk(clk), .rstn(rstn), .bus(ssl_bus_if_i),
    .xfer_go(xfer_go), .xfer_phase(xfer_phase), .xfer_wdata(xfer_wdata),
    .xfer_lanes(xfer_lanes), .resel_go(resel_go), .resel_id(resel_id),
    .release_go(release_go), .selected_r(t_sel), .xfer_done_r(t_done),
    .xfer_rdata_r(t_rdata), .par_err_r(t_perr), .atn_seen_r(t_atn),
    .bus_rst_r(t_rst), .busy_r(t_busy));
  ssl_initiator #(.MY_ID(3'h7)) ssl_initiator_i (.clk(clk), .rstn(rstn),
    .bus(ssl_bus_if_i), .sel_go(sel_go), .sel_id(sel_id), .atn_set(atn_set),
    .rst_go(rst_go), .out_data(out_data), .connected_r(i_conn), .word_r(i_word),
    .in_data_r(i_rdata), .par_err_r(i_perr), .bus_rst_r(i_rst));
  ssl_bus_chk ssl_bus_chk_i (.clk(clk), .rstn(rstn), .rst(ssl_bus_if_i.rst),
    .req(ssl_bus_if_i.req), .reqb(ssl_bus_if_i.reqb), .ack(ssl_bus_if_i.ack),
    .ackb(ssl_bus_if_i.ackb), .cd(ssl_bus_if_i.cd), .io(ssl_bus_if_i.io),
    .msg(ssl_bus_if_i.msg), .db(ssl_bus_if_i.db), .dp(ssl_bus_if_i.dp),
    .db_oe_t(ssl_bus_if_i.db_oe_t), .db_oe_i(ssl_bus_if_i.db_oe_i));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_select();
    @(posedge clk);
    sel_id <= 3'h0;
    sel_go <= 1'b1;
    for (k = 0; k < 60 && !(t_sel === 1'b1 && i_conn === 1'b1); k++) @(negedge clk);
    chk_bit(t_sel, 1'b1);
    chk_bit(i_conn, 1'b1);
    chk_bit(ssl_bus_if_i.bsy, 1'b1);
    chk_bit(t_busy, 1'b1);
    @(posedge clk);
    sel_go <= 1'b0;
  endtask

  // one word; lanes beyond 0 only when ln asks for them
  task automatic do_xfer(input ssl_pkg::ssl_phase_t ph, input logic [3:0] ln,
                         input logic [31:0] d);
    logic [31:0] m;
    logic [2:0]  p;
    int          nw;
    m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, 8'hff};
    nw = 0;
    @(posedge clk);
    xfer_phase <= ph;
    xfer_lanes <= ln;
    xfer_wdata <= d;
    out_data   <= d;
    xfer_go    <= 1'b1;
    @(posedge clk);
    xfer_go <= 1'b0;
    for (k = 0; k < 20 && ssl_bus_if_i.req !== 1'b1; k++) @(negedge clk);
    p = {ssl_bus_if_i.msg, ssl_bus_if_i.cd, ssl_bus_if_i.io};
    chk_word(32'(p), 32'(ph));
    chk_bit(ssl_bus_if_i.reqb, |ln[3:1]);
    if (ph[0]) chk_word(ssl_bus_if_i.db & m, d & m);
    for (k = 0; k < 30 && t_done !== 1'b1; k++) begin
      if (i_word === 1'b1) nw++;
      @(negedge clk);
    end
    chk_bit(t_done, 1'b1);
    chk_word(32'(nw), 32'h0000_0001);
    if (ph[0]) chk_word(i_rdata & m, d & m);
    else chk_word(t_rdata & m, d & m);
    chk_bit(t_perr | i_perr, 1'b0);
  endtask

  task automatic do_atn();
    @(posedge clk);
    atn_set <= 1'b1;
    for (k = 0; k < 20 && t_atn !== 1'b1; k++) @(negedge clk);
    chk_bit(ssl_bus_if_i.atn, 1'b1);
    chk_bit(t_atn, 1'b1);
    @(posedge clk);
    atn_set <= 1'b0;
  endtask

  task automatic do_release();
    @(posedge clk);
    release_go <= 1'b1;
    for (k = 0; k < 40 && ssl_bus_if_i.bsy !== 1'b0; k++) @(negedge clk);
    chk_bit(ssl_bus_if_i.bsy, 1'b0);
    chk_bit(t_busy, 1'b0);
    @(posedge clk);
    release_go <= 1'b0;
  endtask

  task automatic do_resel();
    @(posedge clk);
    resel_id <= 3'h7;
    resel_go <= 1'b1;
    for (k = 0; k < 60 && ssl_bus_if_i.sel !== 1'b1; k++) @(negedge clk);
    chk_bit(ssl_bus_if_i.sel, 1'b1);
    chk_bit(ssl_bus_if_i.io, 1'b1);
    for (k = 0; k < 60 && !(t_sel === 1'b1 && i_conn === 1'b1); k++) @(negedge clk);
    chk_bit(t_sel & i_conn, 1'b1);
    chk_bit(ssl_bus_if_i.bsy, 1'b1);
    @(posedge clk);
    resel_go <= 1'b0;
  endtask

  task automatic do_bus_rst();
    @(posedge clk);
    rst_go <= 1'b1;
    for (k = 0; k < 20 && !(t_rst === 1'b1 && i_rst === 1'b1); k++) @(negedge clk);
    chk_bit(ssl_bus_if_i.rst, 1'b1);
    chk_bit(t_rst & i_rst, 1'b1);
    @(posedge clk);
    rst_go <= 1'b0;
    repeat (8) @(negedge clk);
    chk_bit(t_sel | i_conn, 1'b0);
  endtask

  ssl_pkg::ssl_phase_t ph_tab [6] = '{ssl_pkg::SSL_PH_DATA_IN, ssl_pkg::SSL_PH_DATA_OUT,
    ssl_pkg::SSL_PH_COMMAND, ssl_pkg::SSL_PH_STATUS, ssl_pkg::SSL_PH_MSG_OUT,
    ssl_pkg::SSL_PH_MSG_IN};
  logic [31:0] dat_tab [6] = '{32'h0000_0080, 32'h0000_0001, 32'h0000_00ff,
    32'h0000_0000, 32'h0000_007f, 32'h0000_00a5};

  initial begin
    {rstn, xfer_go, resel_go, release_go, sel_go, atn_set, rst_go} = 7'h00;
    {xfer_wdata, out_data, xfer_lanes, resel_id, sel_id} = 74'h0;
    xfer_phase = ssl_pkg::SSL_PH_DATA_OUT;
    errors = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    do_select();
    for (int i = 0; i < 6; i++) do_xfer(ph_tab[i], 4'h1, dat_tab[i]);
    do_xfer(ssl_pkg::SSL_PH_DATA_IN, 4'hf, 32'h8001_7f3c);
    do_xfer(ssl_pkg::SSL_PH_DATA_OUT, 4'hf, 32'hff00_0100);
    do_atn();
    do_release();
    do_resel();
    do_bus_rst();
    report_and_stop();
  end

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule // scsi_bus_signal_layer_tb
